// ---- hw/dici_top.sv ----
// Purpose: Edge-watching 32-input port with debounce, group byte and interrupt
// Assumes: All inputs synchronous to clk; APB slave
// Notes:   Outputs come from flip-flops; debounce counts are parameters
//
// Implementation choices: the address map and the APB register port.
`default_nettype none
module dici_top
  import dici_pkg::*;
#(
  parameter int DEB_0P3 = CYC_0P3,
  parameter int DEB_1   = CYC_1,
  parameter int DEB_3   = CYC_3
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] processIn,
  input  wire logic        enableIn,
  input  wire logic        group_ack_jumper,
  input  wire logic [7:0]  outShort,
  input  wire logic [7:0]  outOvercurrent,
  output logic             faultSignal,
  output logic             irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0]         config_r;
  logic [31:0]         filt_r;
  logic [31:0]         capture_r;
  logic [3:0]          pending_r;
  logic                frozen_r;
  logic [STATUS_W-1:0] status_r;
  logic [STATUS_W-1:0] mask_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic                fault_r;
  logic                irq_r;
  logic [3:0]          edgeHit;
  logic [7:0]          groupValue;
  logic                done;
  logic                faultNow;
  logic [STATUS_W-1:0] statusSet;

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign faultSignal = fault_r;
  assign irq         = irq_r;

  // Access phase completes on this edge
  assign done = psel && penable && pready_r;

  // ---------------------------------------------------------------
  // Per-byte debounce and edge detection
  // ---------------------------------------------------------------
  for (genvar b = 0; b < 4; b++) begin : g_byte
    logic [15:0] cnt_r;
    logic [15:0] limit;
    logic [1:0]  esel;
    logic [7:0]  raw;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [7:0]  nxtFilt;
    assign raw  = processIn[8*b +: 8];
    assign esel = config_r[EDGE_LSB + 2*b +: 2];
    // Delay choice per byte
    always_comb begin
      unique case (config_r[DELAY_LSB + 2*b +: 2])
        DELAY_0P3: limit = 16'(DEB_0P3);
        DELAY_1:   limit = 16'(DEB_1);
        default:   limit = 16'(DEB_3);
      endcase
    end
    // Byte accepted only once it has differed from the filtered byte for the full delay
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        cnt_r <= 16'h0000;
      end else if (raw == filt_r[8*b +: 8]) begin
        cnt_r <= 16'h0000;
      end else if (cnt_r >= limit - 16'h0001) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
    assign nxtFilt = (raw != filt_r[8*b +: 8] && cnt_r >= limit - 16'h0001)
                     ? raw : filt_r[8*b +: 8];
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        filt_r[8*b +: 8] <= 8'h00;
      end else begin
        filt_r[8*b +: 8] <= nxtFilt;
      end
    end
    assign rise = nxtFilt & ~filt_r[8*b +: 8];
    assign fall = ~nxtFilt & filt_r[8*b +: 8];
    // None position never yields an event
    always_comb begin
      unique case (esel)
        EDGE_RISE: edgeHit[b] = |rise;
        EDGE_FALL: edgeHit[b] = |fall;
        EDGE_BOTH: edgeHit[b] = |(rise | fall);
        default:   edgeHit[b] = 1'b0;
      endcase
    end
    // Pending flag: set beats the read clear
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        pending_r[b] <= 1'b0;
      end else if (edgeHit[b]) begin
        pending_r[b] <= 1'b1;
      end else if (done && !pwrite && paddr == ADDR_DATA0 + 8'(4*b)) begin
        pending_r[b] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture freeze across a four-byte scan
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frozen_r <= 1'b0;
    end else if (done && !pwrite && paddr == ADDR_DATA0) begin
      frozen_r <= 1'b1;
    end else if (done && !pwrite && paddr == ADDR_DATA3) begin
      frozen_r <= 1'b0;
    end
  end

  // Snapshot held still so the four bytes form one coherent sample
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capture_r <= 32'h0000_0000;
    end else if (!frozen_r) begin
      capture_r <= filt_r;
    end
  end

  // Group byte: master owns bit 0 and unclaimed bits, slave one bit
  always_comb begin
    groupValue = 8'h00;
    if (config_r[MASTER_BIT]) begin
      groupValue = {8{|pending_r}} & ~{config_r[TAKEN_LSB + 1 +: 7], 1'b0};
    end else if (config_r[GBIT_LSB +: 3] != 3'h0) begin
      groupValue[config_r[GBIT_LSB +: 3]] = |pending_r;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, silent while disabled
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && penable && !pready_r && enableIn;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (psel && penable && !pready_r) begin
        unique case (paddr)
          ADDR_DATA0:  prdata_r <= {24'h000000, capture_r[7:0]};
          ADDR_DATA1:  prdata_r <= {24'h000000, capture_r[15:8]};
          ADDR_DATA2:  prdata_r <= {24'h000000, capture_r[23:16]};
          ADDR_DATA3:  prdata_r <= {24'h000000, capture_r[31:24]};
          ADDR_CONFIG: prdata_r <= config_r;
          ADDR_GROUP: begin
            prdata_r  <= group_ack_jumper ? {24'h000000, groupValue} : 32'h0000_0000;
            pslverr_r <= !group_ack_jumper;
          end
          ADDR_STATUS: prdata_r <= {27'h0000000, status_r};
          ADDR_MASK:   prdata_r <= {27'h0000000, mask_r};
          default:     pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // Software-written configuration and mask
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config_r <= CONFIG_RESET;
      mask_r   <= '0;
    end else if (done && pwrite) begin
      if (paddr == ADDR_CONFIG) begin
        config_r <= pwdata;
      end
      if (paddr == ADDR_MASK) begin
        mask_r <= pwdata[STATUS_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Fault output and interrupt status
  // ---------------------------------------------------------------
  assign faultNow = |outShort || |outOvercurrent;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= faultNow;
    end
  end

  // Event sources in status bit order; keeps the loop index in range
  assign statusSet = {faultNow, edgeHit};

  // Sticky bits, write one to clear; a new event wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= '0;
    end else begin
      for (int i = 0; i < STATUS_W; i++) begin
        if (statusSet[i]) begin
          status_r[i] <= 1'b1;
        end else if (done && pwrite && paddr == ADDR_STATUS && pwdata[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_edge_rise_sets: assert property (
    (config_r[1:0] == EDGE_RISE && |(g_byte[0].nxtFilt & ~filt_r[7:0])) |=> pending_r[0])
    else $error("rising edge on byte 0 did not set pending");
  a_none_no_event: assert property (
    (config_r[1:0] == EDGE_NONE && !pending_r[0]) |=> !pending_r[0])
    else $error("byte 0 with no edge selected raised an event");
  a_debounce_stable: assert property (
    $changed(filt_r[7:0]) |-> $past(processIn[7:0]) == filt_r[7:0])
    else $error("filtered byte took an unsettled value");
  a_master_bit0: assert property (
    (config_r[MASTER_BIT] && |pending_r) |-> groupValue[0])
    else $error("master did not report on group bit 0");
  a_no_ack_off: assert property (
    !enableIn |=> !pready_r)
    else $error("acknowledged while enable input absent");
  a_fault_follow: assert property (
    faultNow |=> fault_r)
    else $error("fault output missed an output fault");
  a_freeze_scan: assert property (
    (done && !pwrite && paddr == ADDR_DATA0) |=> frozen_r ##1 $stable(capture_r)[*2])
    else $error("capture not frozen after byte 0 read");
  a_release_scan: assert property (
    (done && !pwrite && paddr == ADDR_DATA3) |=> !frozen_r)
    else $error("capture not released after byte 3 read");
  a_group_nack: assert property (
    (done && paddr == ADDR_GROUP && !group_ack_jumper) |-> pslverr_r)
    else $error("group byte acknowledged with jumper open");
  a_read_clears: assert property (
    (done && !pwrite && paddr == ADDR_DATA1 && !edgeHit[1]) |=> !pending_r[1])
    else $error("byte 1 read did not clear pending");

  c_full_scan: cover property (
    (done && paddr == ADDR_DATA0) ##[1:20] (done && paddr == ADDR_DATA3));
  c_irq_raised: cover property (irq_r);
  c_fault_seen: cover property (fault_r);
  c_group_event: cover property (groupValue != 8'h00);
endmodule
`default_nettype wire

// ---- pkg/dici_pkg.sv ----
// Purpose: Constants for the digital input change interrupt block
// Assumes: 20 MHz clk, APB slave with 32-bit data
// Notes:   Functional notes below
//
// Functional notes
// - Each byte detects rising, falling or both edges as its edge select says.
// - A byte whose edge select is none never raises an event.
// - Each byte is debounced by 0.3 ms, 1 ms or 3 ms as its delay select says.
// - A master reports on group bit 0 and on bits no slave takes; a slave on its bit 1..7.
// - Without the enable input the block gives no bus acknowledgement.
// - The fault output is raised on any output short to ground or overcurrent.
// - Bytes are read in ascending order; byte 0 freezes capture and byte 3 releases it.
// - With the group ack jumper open the group byte is not acknowledged.
`default_nettype none
package dici_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA0  = 8'h00;
  localparam logic [7:0] ADDR_DATA1  = 8'h04;
  localparam logic [7:0] ADDR_DATA2  = 8'h08;
  localparam logic [7:0] ADDR_DATA3  = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_GROUP  = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK   = 8'h1C;
  // ---------------------------------------------------------------
  // Config fields and reset value
  // ---------------------------------------------------------------
  localparam int EDGE_LSB   = 0;   // 2 bits per byte
  localparam int DELAY_LSB  = 8;   // 2 bits per byte
  localparam int MASTER_BIT = 16;
  localparam int GBIT_LSB   = 18;  // 3 bits, slave group bit
  localparam int TAKEN_LSB  = 24;  // 8 bits, bits held by slaves
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam int STATUS_W   = 5;   // bits 3:0 byte events, bit 4 fault
  localparam int FAULT_BIT  = 4;
  // Edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Delay select codes (3 also means 3 ms)
  localparam logic [1:0] DELAY_0P3 = 2'h0;
  localparam logic [1:0] DELAY_1   = 2'h1;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 20_000_000;
  localparam int DELAY_0P3_US = 300;
  localparam int DELAY_1_US   = 1000;
  localparam int DELAY_3_US   = 3000;
  localparam int CYC_0P3 = DELAY_0P3_US * (CLK_HZ / 1_000_000);
  localparam int CYC_1   = DELAY_1_US * (CLK_HZ / 1_000_000);
  localparam int CYC_3   = DELAY_3_US * (CLK_HZ / 1_000_000);
endpackage
`default_nettype wire

// ---- sim/dici_apb_host.sv ----
// Purpose: APB master acting as the controller CPU on the backplane bus
// Assumes: Slave answers with pready, sampled at rising clk
// Notes:   A wait is cut after 20 cycles and reported as no answer
`default_nettype none
module dici_apb_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // One transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok  = (pready === 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the input change interrupt port
// Assumes: Short debounce counts; all inputs settle within SETTLE cycles
// Notes:   Model tracks filtered bytes, pending flags and status
`default_nettype none
module tb_top
  import dici_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 40; // Longer than the slowest debounce
  logic        clk = 1'b0, reset = 1'b1, psel, penable, pwrite, pready, pslverr;
  logic        enableIn = 1'b1, groupAck = 1'b1, faultSignal, irq, e, ok;
  logic [7:0]  paddr, outShort = 8'h00, outOc = 8'h00, mData[4] = '{4{8'h00}};
  logic [31:0] pwdata, prdata, processIn = 32'h0, cfg = 32'h0, v, d;
  logic [3:0]  mPend = 4'h0;
  logic [4:0]  mStat = 5'h00, mMask = 5'h00;
  int          n_errors = 0, compares = 0, seed = 93666;
  always #25 clk = ~clk;
  dici_top #(.DEB_0P3(4), .DEB_1(6), .DEB_3(20)) dut (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .processIn(processIn),
    .enableIn(enableIn), .group_ack_jumper(groupAck), .outShort(outShort),
    .outOvercurrent(outOc), .faultSignal(faultSignal), .irq(irq));
  dici_apb_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("Compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A missing answer here is a hang, so the run is closed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    host.xfer(w, a, wd, d, e, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR pready expected 1 seen 0");
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eErr);
    bus(1'b0, a, 32'h0);
    chk($sformatf("prdata@%h", a), d, exp);
    chk($sformatf("pslverr@%h", a), {31'h0, e}, {31'h0, eErr});
  endtask
  // Expected group byte: master owns bit 0 and untaken bits
  function automatic logic [7:0] grp();
    if (mPend == 4'h0) return 8'h00;
    if (cfg[MASTER_BIT]) return ~{cfg[31:25], 1'b0};
    return (cfg[20:18] == 3'h0) ? 8'h00 : 8'h01 << cfg[20:18];
  endfunction
  // Drive a new input word, let it settle, then advance the model
  task automatic step(input logic [31:0] nv);
    logic [7:0] o;
    logic [1:0] c;
    logic       hit;
    processIn <= nv;
    repeat (SETTLE) @(posedge clk);
    for (int n = 0; n < 4; n++) begin
      o = mData[n];
      c = cfg[2*n +: 2];
      hit = (c[0] && |(~o & nv[8*n +: 8])) || (c[1] && |(o & ~nv[8*n +: 8]));
      mPend[n] |= hit;
      mStat[n] |= hit;
      mData[n] = nv[8*n +: 8];
    end
  endtask
  // Status, irq, group byte, ascending scan, then clear status
  task automatic checkAll();
    rd(ADDR_STATUS, {27'h0, mStat}, 1'b0);
    chk("irq", {31'h0, irq}, {31'h0, |(mStat & mMask)});
    rd(ADDR_GROUP, {24'h0, grp()}, 1'b0);
    for (int n = 0; n < 4; n++) begin
      rd(ADDR_DATA0 + 8'(4*n), {24'h0, mData[n]}, 1'b0);
      mPend[n] = 1'b0;
    end
    rd(ADDR_GROUP, 32'h0, 1'b0);
    bus(1'b1, ADDR_STATUS, {27'h0, mStat});
    mStat = 5'h00;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CONFIG, CONFIG_RESET, 1'b0);
    rd(ADDR_MASK, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    mMask = 5'h1F;
    bus(1'b1, ADDR_MASK, 32'h1F);
    // Master with rise/fall/both/none, then slave on bit 5 with rotated edges
    for (int k = 0; k < 2; k++) begin
      cfg = (k == 0) ? 32'h0E01_E439 : 32'h0014_E4E4;
      bus(1'b1, ADDR_CONFIG, cfg);
      rd(ADDR_CONFIG, cfg, 1'b0);
      repeat (4) begin
        step($random(seed));
        checkAll();
      end
    end
    // Fast bytes accepted before slow ones; capture frozen by byte 0 read
    v = ~{mData[3], mData[2], mData[1], mData[0]};
    processIn <= v;
    repeat (12) @(posedge clk);
    rd(ADDR_DATA0, {24'h0, v[7:0]}, 1'b0);
    rd(ADDR_DATA1, {24'h0, v[15:8]}, 1'b0);
    rd(ADDR_DATA2, {24'h0, mData[2]}, 1'b0);
    rd(ADDR_DATA3, {24'h0, mData[3]}, 1'b0);
    step(v);
    // Slow bytes' edges land before their reads, so every read clears
    mPend = 4'h0;
    checkAll();
    // Change while frozen must not show until byte 3 is read
    rd(ADDR_DATA0, {24'h0, mData[0]}, 1'b0);
    processIn <= ~v;
    repeat (SETTLE) @(posedge clk);
    rd(ADDR_DATA1, {24'h0, mData[1]}, 1'b0);
    rd(ADDR_DATA2, {24'h0, mData[2]}, 1'b0);
    rd(ADDR_DATA3, {24'h0, mData[3]}, 1'b0);
    step(~v);
    // Bytes 1..3 were read after their edges, so only byte 0 may stay
    mPend[3:1] = 3'h0;
    checkAll();
    // Short glitch is filtered out
    processIn <= v ^ 32'h0000_0101;
    repeat (2) @(posedge clk);
    step(~v);
    checkAll();
    // Masking hides the interrupt, unmasking shows it again
    step(v);
    mMask = 5'h00;
    bus(1'b1, ADDR_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    mMask = 5'h1F;
    bus(1'b1, ADDR_MASK, 32'h1F);
    repeat (2) @(posedge clk);
    checkAll();
    // Short, then overcurrent, on single outputs
    for (int k = 0; k < 2; k++) begin
      if (k == 0) outShort <= 8'h08;
      else outOc <= 8'h40;
      repeat (3) @(posedge clk);
      chk("faultSignal", {31'h0, faultSignal}, 32'h1);
      outShort <= 8'h00;
      outOc    <= 8'h00;
      repeat (3) @(posedge clk);
      chk("faultSignal", {31'h0, faultSignal}, 32'h0);
      mStat[FAULT_BIT] = 1'b1;
      checkAll();
    end
    groupAck <= 1'b0;
    rd(ADDR_GROUP, 32'h0, 1'b1);
    groupAck <= 1'b1;
    enableIn <= 1'b0;
    host.xfer(1'b0, ADDR_CONFIG, 32'h0, d, e, ok);
    chk("ack", {31'h0, ok}, 32'h0);
    enableIn <= 1'b1;
    rd(ADDR_CONFIG, cfg, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
